/* odtdq_ctrl_model.sv */
// Purpose: Controller model with a free CK and command pins.
// Assumes: A command is set at a CK fall and held one CK period.
// Notes: Released address and data show the inverse value.
`timescale 1ns/1ps
module odtdq_ctrl_model
(
    input wire logic clk_i,
    output logic ck_o,
    output logic mrw_o,
    output logic mrr_o,
    output logic mpc_o,
    output logic [5:0] addr_o,
    output logic [7:0] data_o
);
    initial
    begin
        ck_o = 1'b0;
        {mrw_o, mrr_o, mpc_o, addr_o, data_o} = '0;
        forever #40 ck_o = ~ck_o;
    end
    // Setup of 35 ns and hold of 45 ns keep the pins steady around CK rise.
    task automatic send(input logic [2:0] k, input logic [5:0] a, input logic [7:0] d);
        @(negedge ck_o);
        @(posedge clk_i);
        {mrw_o, mrr_o, mpc_o} <= k;
        addr_o <= a;
        data_o <= d;
        @(negedge ck_o);
        @(posedge clk_i);
        {mrw_o, mrr_o, mpc_o} <= 3'h0;
        addr_o <= ~a;
        data_o <= ~d;
    endtask
endmodule

/* odtdq_dqs_timer.sv */
// Purpose: DQS interval timer that runs in command clock ticks.
// Assumes: tick_i is a one-cycle pulse per command clock rising edge.
// Notes: A start during a run restarts the count from zero.
`timescale 1ns/1ps
module odtdq_dqs_timer
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [7:0] run_time_i,
    output logic running_o
);
    typedef enum logic [1:0]
    {
        ODTDQ_IDLE = 2'b01,
        ODTDQ_RUN = 2'b10
    } odtdq_tstate_t;

    typedef struct packed
    {
        odtdq_tstate_t st;
        logic [odtdq_pkg::CNT_W-1:0] cnt;
    } odtdq_timer_t;

    odtdq_timer_t q, d;
    logic [odtdq_pkg::CNT_W-1:0] limit;
    logic [odtdq_pkg::CNT_W-1:0] cnt_inc;

    always_comb
    begin
        d = q;
        if (run_time_i > odtdq_pkg::RUN_TIME_MAX)
        begin
            limit = 7'(odtdq_pkg::TIMER_STEP_CLKS * 7'(odtdq_pkg::RUN_TIME_MAX));
        end
        else
        begin
            limit = 7'(odtdq_pkg::TIMER_STEP_CLKS * 7'(run_time_i));
        end
        cnt_inc = q.cnt + 7'h01;
        case (q.st)
            ODTDQ_IDLE:
            begin
                if (start_i)
                begin
                    d.st = ODTDQ_RUN;
                    d.cnt = 7'h00;
                end
            end
            ODTDQ_RUN:
            begin
                if (start_i)
                begin
                    d.cnt = 7'h00;
                end
                else if (stop_i && run_time_i == 8'h00)
                begin
                    d.st = ODTDQ_IDLE;
                end
                else if (tick_i)
                begin
                    d.cnt = cnt_inc;
                    if (limit != 7'h00 && cnt_inc >= limit)
                    begin
                        d.st = ODTDQ_IDLE;
                    end
                end
            end
            default:
            begin
                d.st = ODTDQ_IDLE;
                d.cnt = 7'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= '{st: ODTDQ_IDLE, cnt: 7'h00};
        end
        else
        begin
            q <= d;
        end
    end

    assign running_o = (q.st == ODTDQ_RUN);
endmodule

/* odtdq_pkg.sv */
// Purpose: Shared constants for the termination select and DQS timer logic.
// Assumes: Mode register addresses are six bits and operands eight bits.
// Notes: Every offset, field position, reset value and count is named here once.
package odtdq_pkg;
    localparam logic [5:0] TERM_DISABLE_ADDR = 6'h16;
    localparam logic [5:0] DQS_RUN_TIME_ADDR = 6'h17;
    localparam logic [7:0] TERM_DISABLE_RESET = 8'h00;
    localparam logic [7:0] DQS_RUN_TIME_RESET = 8'h00;
    localparam int CK_CLK_BIT = 3;
    localparam int CS_OFF_BIT = 4;
    localparam int CA_OFF_BIT = 5;
    localparam int LOWER_BYTE_OFF_BIT = 6;
    localparam int UPPER_BYTE_OFF_BIT = 7;
    localparam int BYTE_MODE_LSB = 4;
    localparam int BYTE_MODE_MSB = 6;
    localparam logic [6:0] STOP_OSC_CODE = 7'h4d;
    localparam logic [6:0] START_OSC_CODE = 7'h4b;
    localparam logic [6:0] TIMER_STEP_CLKS = 7'h10;
    localparam logic [7:0] RUN_TIME_MAX = 8'h04;
    localparam int CNT_W = 7;
endpackage

/* odtdq_regs.sv */
// Purpose: Termination disable set points, run time register and command decode.
// Assumes: Command pins are stable around each rising edge of the command clock.
// Notes: Pins pass two flip-flops; the command clock edge is found by sampling.
// How it works
// - Two copies per disable bit; write and read use the write set point.
// - Termination is driven only from the copy of the operating set point.
// - Bond input is ignored; enable and disable registers alone decide termination.
// - Per-byte table applies only while byte-mode field bits 6 to 4 are nonzero.
// - Bits 5,4,3 drop CA, CS, CK; bits 6,7 drop lower, upper byte.
// - Run time register is write-only, resets to zero; zero means stop by command.
// - Run time N from 1 to 4 stops the timer 16 times N clocks later.
// - Stop-oscillator command halts the timer while run time is zero.
// - A start-oscillator command clears count registers and starts the timer.
`timescale 1ns/1ps
module odtdq_regs
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ck_i,
    input wire logic cmd_mrw_i,
    input wire logic cmd_mrr_i,
    input wire logic cmd_mpc_i,
    input wire logic [5:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic termination_bond_input_i,
    input wire logic write_set_point_select_i,
    input wire logic operating_set_point_select_i,
    input wire logic [7:0] termination_enable_register_i,
    output logic [7:0] mrr_data_o,
    output logic mrr_valid_o,
    output logic ca_term_lower_o,
    output logic ca_term_upper_o,
    output logic cs_term_lower_o,
    output logic cs_term_upper_o,
    output logic ck_term_lower_o,
    output logic ck_term_upper_o,
    output logic osc_count_clear_o,
    output logic dqs_timer_running_o
);
    localparam int SW = 18;

    typedef struct packed
    {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic ck_prev;
        logic [7:0] tdis0;
        logic [7:0] tdis1;
        logic [7:0] run_time;
        logic [7:0] rd_data;
        logic rd_valid;
        logic clr;
        logic [5:0] term;
    } odtdq_state_t;

    odtdq_state_t q, d;
    logic ck_s, mrw_s, mrr_s, mpc_s;
    logic [5:0] addr_s;
    logic [7:0] data_s;
    logic ck_rise, start_p, stop_p;
    logic [7:0] active;
    logic [7:0] wr_copy;
    logic enabled;
    logic [1:0] hit, op;

    // A lane is terminated only if enabled and neither its byte nor its signal is dropped.
    function automatic logic term_on(input logic en, input logic byte_off, input logic sig_off);
        term_on = en & ~byte_off & ~sig_off;
    endfunction

    // Address decode shared by the write and read paths; bit 0 is the disable register.
    function automatic logic [1:0] reg_hit(input logic [5:0] addr);
        logic [1:0] hit_v;
        hit_v = 2'b00;
        if (addr == odtdq_pkg::TERM_DISABLE_ADDR)
        begin
            hit_v = 2'b01;
        end
        else if (addr == odtdq_pkg::DQS_RUN_TIME_ADDR)
        begin
            hit_v = 2'b10;
        end
        reg_hit = hit_v;
    endfunction

    // Only the low seven operand bits select the operation, so bit 7 is ignored.
    function automatic logic [1:0] osc_op(input logic [7:0] operand);
        logic [1:0] op_v;
        op_v = 2'b00;
        if (operand[6:0] == odtdq_pkg::START_OSC_CODE)
        begin
            op_v = 2'b01;
        end
        else if (operand[6:0] == odtdq_pkg::STOP_OSC_CODE)
        begin
            op_v = 2'b10;
        end
        osc_op = op_v;
    endfunction

    assign {ck_s, mrw_s, mrr_s, mpc_s, addr_s, data_s} = q.s2;

    always_comb
    begin
        d = q;
        d.s1 = {ck_i, cmd_mrw_i, cmd_mrr_i, cmd_mpc_i, cmd_addr_i, cmd_data_i};
        d.s2 = q.s1;
        d.ck_prev = ck_s;
        ck_rise = ck_s & ~q.ck_prev;
        d.rd_valid = 1'b0;
        d.clr = 1'b0;
        start_p = 1'b0;
        stop_p = 1'b0;
        hit = reg_hit(addr_s);
        op = osc_op(data_s);
        // Copy chosen by write set point.
        wr_copy = write_set_point_select_i ? q.tdis1 : q.tdis0;
        if (ck_rise && mrw_s)
        begin
            if (hit[0])
            begin
                if (write_set_point_select_i)
                begin
                    d.tdis1 = data_s;
                end
                else
                begin
                    d.tdis0 = data_s;
                end
            end
            else if (hit[1])
            begin
                d.run_time = data_s;
            end
        end
        else if (ck_rise && mrr_s)
        begin
            d.rd_valid = 1'b1;
            if (hit[0])
            begin
                d.rd_data = wr_copy;
            end
            else
            begin
                d.rd_data = 8'h00;
            end
        end
        else if (ck_rise && mpc_s)
        begin
            if (op[0])
            begin
                start_p = 1'b1;
                d.clr = 1'b1;
            end
            // Stop with nonzero run time is ignored.
            else if (op[1])
            begin
                stop_p = 1'b1;
            end
        end
        active = operating_set_point_select_i ? q.tdis1 : q.tdis0;
        enabled = termination_enable_register_i[odtdq_pkg::BYTE_MODE_MSB:odtdq_pkg::BYTE_MODE_LSB]
            != 3'b000;
        // Bond input unused here; per-byte decode.
        d.term[0] = term_on(enabled, active[odtdq_pkg::LOWER_BYTE_OFF_BIT],
            active[odtdq_pkg::CA_OFF_BIT]);
        d.term[1] = term_on(enabled, active[odtdq_pkg::UPPER_BYTE_OFF_BIT],
            active[odtdq_pkg::CA_OFF_BIT]);
        d.term[2] = term_on(enabled, active[odtdq_pkg::LOWER_BYTE_OFF_BIT],
            active[odtdq_pkg::CS_OFF_BIT]);
        d.term[3] = term_on(enabled, active[odtdq_pkg::UPPER_BYTE_OFF_BIT],
            active[odtdq_pkg::CS_OFF_BIT]);
        d.term[4] = term_on(enabled, active[odtdq_pkg::LOWER_BYTE_OFF_BIT],
            active[odtdq_pkg::CK_CLK_BIT]);
        d.term[5] = term_on(enabled, active[odtdq_pkg::UPPER_BYTE_OFF_BIT],
            active[odtdq_pkg::CK_CLK_BIT]);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= '{s1: '0, s2: '0, ck_prev: 1'b0,
                tdis0: odtdq_pkg::TERM_DISABLE_RESET,
                tdis1: odtdq_pkg::TERM_DISABLE_RESET,
                run_time: odtdq_pkg::DQS_RUN_TIME_RESET,
                rd_data: 8'h00, rd_valid: 1'b0, clr: 1'b0, term: 6'h00};
        end
        else
        begin
            q <= d;
        end
    end

    // The timer counts command clock edges, so its length tracks the command clock rate.
    odtdq_dqs_timer u_odtdq_dqs_timer
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tick_i(ck_rise),
        .start_i(start_p),
        .stop_i(stop_p),
        .run_time_i(q.run_time),
        .running_o(dqs_timer_running_o)
    );

    assign mrr_data_o = q.rd_data;
    assign mrr_valid_o = q.rd_valid;
    assign osc_count_clear_o = q.clr;
    assign ca_term_lower_o = q.term[0];
    assign ca_term_upper_o = q.term[1];
    assign cs_term_lower_o = q.term[2];
    assign cs_term_upper_o = q.term[3];
    assign ck_term_lower_o = q.term[4];
    assign ck_term_upper_o = q.term[5];
endmodule

/* odtdq_regs_props.sv */
// Purpose: Port checks for the termination select and timer logic.
// Assumes: One clock domain.
// Notes: Bound to every instance.
`timescale 1ns/1ps
module odtdq_regs_props
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic write_set_point_select_i,
    input wire logic operating_set_point_select_i,
    input wire logic [7:0] termination_enable_register_i,
    input wire logic [7:0] mrr_data_o,
    input wire logic mrr_valid_o,
    input wire logic ca_term_lower_o,
    input wire logic ca_term_upper_o,
    input wire logic cs_term_lower_o,
    input wire logic cs_term_upper_o,
    input wire logic ck_term_lower_o,
    input wire logic ck_term_upper_o,
    input wire logic osc_count_clear_o,
    input wire logic dqs_timer_running_o
);
    wire [5:0] term = {ca_term_lower_o, ca_term_upper_o, cs_term_lower_o,
        cs_term_upper_o, ck_term_lower_o, ck_term_upper_o};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_mrr_pulse: assert property (mrr_valid_o |=> !mrr_valid_o)
        else $error("read valid held too long");
    a_data_hold: assert property ($changed(mrr_data_o) |-> mrr_valid_o)
        else $error("read data moved without valid");
    a_op_only: assert property ($changed(term) && $past(rstn_i, 2) |->
        $changed($past(operating_set_point_select_i)) || $changed($past(termination_enable_register_i))
        || $past(write_set_point_select_i, 2) == $past(operating_set_point_select_i, 2))
        else $error("termination moved by inactive copy");
    a_field_zero: assert property (termination_enable_register_i[6:4] == 3'h0 |=> term == 6'h00)
        else $error("terminated with byte field zero");
    a_byte_off: assert property (ca_term_lower_o && !ca_term_upper_o |->
        !cs_term_upper_o && !ck_term_upper_o) else $error("upper byte partly on");
    a_clr_pulse: assert property (osc_count_clear_o |=> !osc_count_clear_o)
        else $error("clear pulse too long");
    a_start_runs: assert property (osc_count_clear_o |-> dqs_timer_running_o)
        else $error("start without running");
    a_run_cause: assert property ($rose(dqs_timer_running_o) |-> osc_count_clear_o)
        else $error("timer ran without start");
endmodule
bind odtdq_regs odtdq_regs_props u_odtdq_regs_props (.*);

/* test_odtdq_regs.sv */
// Purpose: Self-checking bench for the termination select and timer logic.
// Assumes: Controller model drives the command pins.
// Notes: Expected termination is rebuilt from the disable bits.
`timescale 1ns/1ps
module test_odtdq_regs;
    logic clk_i, rstn_i, ck_i, cmd_mrw_i, cmd_mrr_i, cmd_mpc_i, termination_bond_input_i;
    logic write_set_point_select_i, operating_set_point_select_i;
    logic [5:0] cmd_addr_i;
    logic [7:0] cmd_data_i, termination_enable_register_i, mrr_data_o;
    logic mrr_valid_o, ca_term_lower_o, ca_term_upper_o, cs_term_lower_o, cs_term_upper_o;
    logic ck_term_lower_o, ck_term_upper_o, osc_count_clear_o, dqs_timer_running_o;
    int n_mismatch, comparisons, n;
    wire [7:0] term = {2'h0, ca_term_lower_o, ca_term_upper_o, cs_term_lower_o,
        cs_term_upper_o, ck_term_lower_o, ck_term_upper_o};
    odtdq_regs u_odtdq_regs (.*);
    odtdq_ctrl_model u_odtdq_ctrl_model (.clk_i(clk_i), .ck_o(ck_i), .mrw_o(cmd_mrw_i),
        .mrr_o(cmd_mrr_i), .mpc_o(cmd_mpc_i), .addr_o(cmd_addr_i), .data_o(cmd_data_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] k, input logic [5:0] a, input logic [7:0] d);
        u_odtdq_ctrl_model.send(k, a, d);
        repeat (4) @(posedge clk_i);
    endtask
    function automatic logic [7:0] ex(input logic [7:0] d);
        logic [2:0] x;
        x = ~d[5:3];
        return {2'h0, x[2] & ~d[6], x[2] & ~d[7], x[1] & ~d[6], x[1] & ~d[7],
            x[0] & ~d[6], x[0] & ~d[7]};
    endfunction
    task automatic t_set_points;
        logic [7:0] v [8] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hc0, 8'h68};
        foreach (v[i])
        begin
            write_set_point_select_i <= 1'b1;
            cmd(3'h4, 6'h16, ~v[i]);
            write_set_point_select_i <= 1'b0;
            cmd(3'h4, 6'h16, v[i]);
            termination_enable_register_i <= 8'h10;
            termination_bond_input_i <= ~termination_bond_input_i;
            cmd(3'h2, 6'h16, 8'h00);
            check(mrr_data_o, v[i]);
            check(term, ex(v[i]));
            termination_bond_input_i <= ~termination_bond_input_i;
            repeat (3) @(posedge clk_i);
            check(term, ex(v[i]));
            write_set_point_select_i <= 1'b1;
            operating_set_point_select_i <= 1'b1;
            cmd(3'h2, 6'h16, 8'h00);
            check(mrr_data_o, ~v[i]);
            check(term, ex(~v[i]));
            operating_set_point_select_i <= 1'b0;
        end
        termination_enable_register_i <= 8'h8f;
        repeat (3) @(posedge clk_i);
        check(term, 8'h00);
    endtask
    task automatic t_timer(input logic [7:0] rt, input logic [7:0] want);
        cmd(3'h4, 6'h17, rt);
        u_odtdq_ctrl_model.send(3'h1, 6'h00, {1'b0, odtdq_pkg::START_OSC_CODE});
        n = 0;
        do
        begin
            @(posedge ck_i);
            repeat (6) @(posedge clk_i);
            n++;
        end
        while (dqs_timer_running_o === 1'b1 && n < 100);
        check(8'(n), want);
    endtask
    task automatic t_stop;
        // run time returns to zero through a mid-run reset.
        cmd(3'h4, 6'h17, 8'h01);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        cmd(3'h2, 6'h16, 8'h00);
        check(mrr_data_o, 8'h00);
        // stop sent only with zero run time.
        cmd(3'h1, 6'h00, {1'b0, odtdq_pkg::START_OSC_CODE});
        repeat (200) @(posedge clk_i);
        check(dqs_timer_running_o, 8'h01);
        cmd(3'h1, 6'h00, {1'b0, odtdq_pkg::STOP_OSC_CODE});
        check(dqs_timer_running_o, 8'h00);
        cmd(3'h2, 6'h17, 8'h00);
        check(mrr_data_o, 8'h00);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        #300000;
        n_mismatch++;
        close_out;
    end
    initial
    begin
        {rstn_i, termination_bond_input_i, termination_enable_register_i} = '0;
        {write_set_point_select_i, operating_set_point_select_i} = 2'b00;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(term, 8'h00);
        t_set_points();
        t_timer(8'h01, 8'h10);
        t_timer(8'h04, 8'h40);
        t_timer(8'h09, 8'h40);
        t_stop();
        close_out();
    end
endmodule
